// >>> include/qsd_cfg.svh
// Constants of the queued send decoder: field positions, codes, offsets.
// Assumes the includer is on one clock at 50 MHz.
`ifndef QSD_CFG_SVH
`define QSD_CFG_SVH
`define QSD_SUB_HI        12
`define QSD_SUB_LO        8
`define QSD_SUB_RSVD_MIN  5'h05
`define QSD_RNG_LEN_HI    63
`define QSD_RNG_LEN_LO    48
`define QSD_RNG_LBA_HI    47
`define QSD_RNG_LBA_LO    0
`define QSD_BLK_ENTRIES   64
`define QSD_AUX_DISCARD   0
`define QSD_AUX_FUNC_HI   15
`define QSD_AUX_FUNC_LO   8
`define QSD_RSVD_LOG      32'hffff_ffff
`define QSD_RSVD_ZONED    32'hffff_0000
`define QSD_RSVD_RANGE    32'hffff_00fe
`define QSD_RSVD_EVICT    32'hffff_fffe
`define QSD_OFF_CTRL      12'h000
`define QSD_OFF_CMD       12'h004
`define QSD_OFF_FEAT      12'h008
`define QSD_OFF_LBALO     12'h00c
`define QSD_OFF_LBAHI     12'h010
`define QSD_OFF_AUX       12'h014
`define QSD_OFF_QWLO      12'h018
`define QSD_OFF_QWHI      12'h01c
`define QSD_OFF_STAT      12'h020
`define QSD_OFF_BASE      12'h024
`define QSD_OFF_PTR       12'h080
`define QSD_CTRL_ISSUE    0
`define QSD_CTRL_LAST     1
`define QSD_CTRL_SEND     3
`define QSD_CMD_TAG_HI    20
`define QSD_CMD_TAG_LO    16
`endif

// >>> include/qsd_pkg.sv
// Types shared by both ends of the queued send decoder.
// Assumes qsd_cfg.svh for numeric constants.
package qsd_pkg;
	typedef enum logic [4:0] {
		SUB_RANGE = 5'h00,
		SUB_EVICT = 5'h01,
		SUB_LOG   = 5'h02,
		SUB_ZONED = 5'h03,
		SUB_XRNG  = 5'h04
	} qsd_sub_type;
	typedef logic [4:0] qsd_tag_type;
endpackage

// >>> include/qsd_link_if.sv
// Link between host adapter end and device end, both on sys_clk.
// Assumes a testbench or top joins the two modports.
`timescale 1ns/1ps
interface qsd_link_if;
	logic                cmdValid;
	logic                cmdReady;
	qsd_pkg::qsd_tag_type cmdTag;
	logic [15:0]         cmdCount;
	logic [15:0]         cmdFeatures;
	logic [47:0]         cmdLba;
	logic [31:0]         cmdAux;
	logic                qwValid;
	logic                qwReady;
	logic [63:0]         qwData;
	logic                qwLast;
	logic                dmaSetup;
	qsd_pkg::qsd_tag_type dmaBufId;
	modport host (output cmdValid, cmdTag, cmdCount, cmdFeatures, cmdLba,
		cmdAux, qwValid, qwData, qwLast, input cmdReady, qwReady,
		dmaSetup, dmaBufId);
	modport dev (input cmdValid, cmdTag, cmdCount, cmdFeatures, cmdLba,
		cmdAux, qwValid, qwData, qwLast, output cmdReady, qwReady,
		dmaSetup, dmaBufId);
endinterface

// >>> src/qsd_device_end.sv
// Device end: decodes queued send subcommands and unpacks range lists.
// Assumes the host keeps valid and fields steady until ready.
//
// Functional notes
// - Range length sits in entry bits 63:48.
// - Starting block address in entry bits 47:0.
// - Block holds entries 0..63, eight bytes each.
// - Log write is sequential, never reordered.
// - Log write: features count, address in LBA.
// - Zoned out completes in issue order.
// - Zoned out: count, address, aux 15:0.
// - Extended range: params, discard, function code.
// - Buffers chosen by identifier, never address.
// - Buffer identifier equals the command tag.
// - Tags and identifiers are five bits.
// - Host indexes pointer table by identifier.
// - Host fills pointer entry before issuing.
// - Offsets needed only for out-of-order data.
// - Subcommand in count 12:8; 05h+ reserved.
// - Zero length ends the range list.
// - Host sorts entries by rising address.
`timescale 1ns/1ps
`include "qsd_cfg.svh"
module qsd_device_end
(
	input  wire logic                 sys_clk,
	input  wire logic                 rst_b,
	qsd_link_if.dev                   link,
	input  wire logic                 cmdDone,
	output logic                      decValid,
	output qsd_pkg::qsd_tag_type      decTag,
	output logic [4:0]                decSubcode,
	output logic                      decInvalid,
	output logic                      decSequential,
	output logic                      decOrdered,
	output logic [15:0]               decCount,
	output logic [47:0]               decAddress,
	output logic [15:0]               decFeatures,
	output logic                      decDiscard,
	output logic [7:0]                decFunction,
	output logic                      rngValid,
	output logic [5:0]                rngIndex,
	output logic [15:0]               rngLength,
	output logic [47:0]               rngStart,
	output logic                      rngListEnd
);
	logic                 cmdReady_q;
	logic                 barrier_q;
	logic                 dmaSetup_q;
	qsd_pkg::qsd_tag_type dmaBufId_q;
	logic                 decValid_q;
	qsd_pkg::qsd_tag_type decTag_q;
	logic [4:0]           decSubcode_q;
	logic                 decInvalid_q;
	logic                 decSeq_q;
	logic                 decOrd_q;
	logic [15:0]          decCount_q;
	logic [47:0]          decAddress_q;
	logic [15:0]          decFeatures_q;
	logic                 decDiscard_q;
	logic [7:0]           decFunction_q;
	logic                 rngValid_q;
	logic [5:0]           rngIndex_q;
	logic [5:0]           entryCnt_q;
	logic                 stopped_q;
	logic [15:0]          rngLength_q;
	logic [47:0]          rngStart_q;
	logic                 rngListEnd_q;
	logic                 cmdTake;
	logic                 qwTake;
	logic [4:0]           subCode;
	logic [31:0]          rsvdMask;
	logic                 codeBad;
	logic                 isSeq;
	logic                 isOrd;
	logic [15:0]          qwLen;

	assign cmdTake = link.cmdValid && cmdReady_q;
	assign qwTake  = link.qwValid;
	assign subCode = link.cmdCount[`QSD_SUB_HI:`QSD_SUB_LO];
	assign codeBad = subCode >= `QSD_SUB_RSVD_MIN;
	assign isSeq   = subCode == qsd_pkg::SUB_LOG;
	// Every zoned out is held ordered; the zoned action is not decoded here
	assign isOrd   = subCode == qsd_pkg::SUB_ZONED;
	assign qwLen   = link.qwData[`QSD_RNG_LEN_HI:`QSD_RNG_LEN_LO];

	always_comb
	begin
		unique case (subCode)
			qsd_pkg::SUB_LOG:   rsvdMask = `QSD_RSVD_LOG;
			qsd_pkg::SUB_ZONED: rsvdMask = `QSD_RSVD_ZONED;
			qsd_pkg::SUB_EVICT: rsvdMask = `QSD_RSVD_EVICT;
			default:            rsvdMask = `QSD_RSVD_RANGE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			barrier_q <= 1'b0;
		else if (cmdTake && !codeBad && (isSeq || isOrd))
			barrier_q <= 1'b1;
		else if (cmdDone)
			barrier_q <= 1'b0;
	end

	// One command per two cycles; barrier stalls the host until done
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			cmdReady_q <= 1'b0;
		else
			cmdReady_q <= !cmdTake && !barrier_q
				&& !(cmdTake && (isSeq || isOrd));
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dmaSetup_q <= 1'b0;
			dmaBufId_q <= 5'h00;
		end
		else
		begin
			dmaSetup_q <= cmdTake && !codeBad
				&& (link.cmdAux & rsvdMask) == 32'h0000_0000
				&& subCode != qsd_pkg::SUB_ZONED;
			if (cmdTake)
				dmaBufId_q <= link.cmdTag;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			decValid_q    <= 1'b0;
			decTag_q      <= 5'h00;
			decSubcode_q  <= 5'h00;
			decInvalid_q  <= 1'b0;
			decSeq_q      <= 1'b0;
			decOrd_q      <= 1'b0;
			decCount_q    <= 16'h0000;
			decAddress_q  <= 48'h0000_0000_0000;
			decFeatures_q <= 16'h0000;
			decDiscard_q  <= 1'b0;
			decFunction_q <= 8'h00;
		end
		else
		begin
			decValid_q <= cmdTake;
			if (cmdTake)
			begin
				decTag_q      <= link.cmdTag;
				decSubcode_q  <= subCode;
				decInvalid_q  <= codeBad
					|| (link.cmdAux & rsvdMask) != 32'h0000_0000;
				decSeq_q      <= isSeq;
				decOrd_q      <= isOrd;
				decCount_q    <= link.cmdFeatures;
				decAddress_q  <= link.cmdLba;
				decFeatures_q <= link.cmdAux[15:0];
				decDiscard_q  <= link.cmdAux[`QSD_AUX_DISCARD];
				decFunction_q <=
					link.cmdAux[`QSD_AUX_FUNC_HI:`QSD_AUX_FUNC_LO];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			entryCnt_q <= 6'h00;
		else if (cmdTake)
			entryCnt_q <= 6'h00;
		else if (qwTake)
			entryCnt_q <= qwTake && link.qwLast ? 6'h00 : entryCnt_q + 6'h01;
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			stopped_q <= 1'b0;
		else if (cmdTake || (qwTake && link.qwLast))
			stopped_q <= 1'b0;
		else if (qwTake && qwLen == 16'h0000)
			stopped_q <= 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rngValid_q   <= 1'b0;
			rngIndex_q   <= 6'h00;
			rngLength_q  <= 16'h0000;
			rngStart_q   <= 48'h0000_0000_0000;
			rngListEnd_q <= 1'b0;
		end
		else
		begin
			rngValid_q   <= qwTake && !stopped_q && qwLen != 16'h0000;
			rngListEnd_q <= qwTake && link.qwLast;
			if (qwTake)
			begin
				rngIndex_q  <= entryCnt_q;
				rngLength_q <= qwLen;
				rngStart_q  <=
					link.qwData[`QSD_RNG_LBA_HI:`QSD_RNG_LBA_LO];
			end
		end
	end

	// Data is never stalled; the range list drains at one entry a cycle
	// in order, no offsets
	assign link.qwReady  = 1'b1;
	assign link.cmdReady = cmdReady_q;
	assign link.dmaSetup = dmaSetup_q;
	assign link.dmaBufId = dmaBufId_q;
	assign decValid      = decValid_q;
	assign decTag        = decTag_q;
	assign decSubcode    = decSubcode_q;
	assign decInvalid    = decInvalid_q;
	assign decSequential = decSeq_q;
	assign decOrdered    = decOrd_q;
	assign decCount      = decCount_q;
	assign decAddress    = decAddress_q;
	assign decFeatures   = decFeatures_q;
	assign decDiscard    = decDiscard_q;
	assign decFunction   = decFunction_q;
	assign rngValid      = rngValid_q;
	assign rngIndex      = rngIndex_q;
	assign rngLength     = rngLength_q;
	assign rngStart      = rngStart_q;
	assign rngListEnd    = rngListEnd_q;
endmodule

// >>> src/qsd_host_end.sv
// Host adapter end: APB registers drive commands and range data.
// Assumes software fills the pointer table before each issue.
`timescale 1ns/1ps
`include "qsd_cfg.svh"
module qsd_host_end
#(
	parameter int PTR_ENTRIES = 32
)
(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	qsd_link_if.host         link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	logic [31:0] cmd_q;
	logic [15:0] feat_q;
	logic [31:0] lbaLo_q;
	logic [15:0] lbaHi_q;
	logic [31:0] aux_q;
	logic [31:0] qwLo_q;
	logic [31:0] qwHi_q;
	logic        qwLast_q;
	logic        cmdValid_q;
	logic        qwValid_q;
	logic [31:0] ptr_q [PTR_ENTRIES];
	logic [31:0] base_q;
	logic [4:0]  bufId_q;
	logic        setupSeen_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        acc;
	logic        wr;
	logic        ptrHit;
	logic [4:0]  ptrIdx;
	logic [31:0] rdVal;
	logic        hit;

	assign acc    = psel && penable && !pready_q;
	// Writes land at the edge that completes the transfer
	assign wr     = psel && penable && pready_q && pwrite;
	assign ptrHit = paddr[11:7] == 5'h01;
	assign ptrIdx = paddr[6:2];

	always_comb
	begin
		hit   = 1'b1;
		rdVal = 32'h0000_0000;
		if (ptrHit)
			rdVal = ptr_q[ptrIdx];
		else
			unique case (paddr)
				`QSD_OFF_CTRL:  rdVal = {30'h0, qwValid_q, cmdValid_q};
				`QSD_OFF_CMD:   rdVal = cmd_q;
				`QSD_OFF_FEAT:  rdVal = {16'h0000, feat_q};
				`QSD_OFF_LBALO: rdVal = lbaLo_q;
				`QSD_OFF_LBAHI: rdVal = {16'h0000, lbaHi_q};
				`QSD_OFF_AUX:   rdVal = aux_q;
				`QSD_OFF_QWLO:  rdVal = qwLo_q;
				`QSD_OFF_QWHI:  rdVal = qwHi_q;
				`QSD_OFF_STAT:  rdVal = {26'h0, setupSeen_q, bufId_q};
				`QSD_OFF_BASE:  rdVal = base_q;
				default:        hit = 1'b0;
			endcase
	end

	// One wait state: answer lands on the second access edge
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q  <= acc;
			pslverr_q <= acc && !hit;
			prdata_q  <= acc && !pwrite ? rdVal : 32'h0000_0000;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cmd_q   <= 32'h0000_0000;
			feat_q  <= 16'h0000;
			lbaLo_q <= 32'h0000_0000;
			lbaHi_q <= 16'h0000;
			aux_q   <= 32'h0000_0000;
			qwLo_q  <= 32'h0000_0000;
			qwHi_q  <= 32'h0000_0000;
		end
		else if (wr && !cmdValid_q && !qwValid_q)
			unique case (paddr)
				`QSD_OFF_CMD:   cmd_q <= pwdata;
				`QSD_OFF_FEAT:  feat_q <= pwdata[15:0];
				`QSD_OFF_LBALO: lbaLo_q <= pwdata;
				`QSD_OFF_LBAHI: lbaHi_q <= pwdata[15:0];
				`QSD_OFF_AUX:   aux_q <= pwdata;
				`QSD_OFF_QWLO:  qwLo_q <= pwdata;
				`QSD_OFF_QWHI:  qwHi_q <= pwdata;
				default:        ;
			endcase
	end

	genvar i;
	generate
		for (i = 0; i < PTR_ENTRIES; i++)
		begin : gPtr
			always_ff @(posedge sys_clk or negedge rst_b)
			begin
				if (!rst_b)
					ptr_q[i] <= 32'h0000_0000;
				else if (wr && ptrHit && ptrIdx == 5'(i))
					ptr_q[i] <= pwdata;
			end
		end
	endgenerate

	// Requests stand until the device takes them
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cmdValid_q <= 1'b0;
			qwValid_q  <= 1'b0;
			qwLast_q   <= 1'b0;
		end
		else
		begin
			if (link.cmdValid && link.cmdReady)
				cmdValid_q <= 1'b0;
			else if (wr && paddr == `QSD_OFF_CTRL
				&& pwdata[`QSD_CTRL_ISSUE])
				cmdValid_q <= 1'b1;
			if (link.qwValid && link.qwReady)
				qwValid_q <= 1'b0;
			else if (wr && paddr == `QSD_OFF_CTRL
				&& pwdata[`QSD_CTRL_SEND])
			begin
				qwValid_q <= 1'b1;
				qwLast_q  <= pwdata[`QSD_CTRL_LAST];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			base_q      <= 32'h0000_0000;
			bufId_q     <= 5'h00;
			setupSeen_q <= 1'b0;
		end
		else if (link.dmaSetup)
		begin
			base_q      <= ptr_q[link.dmaBufId];
			bufId_q     <= link.dmaBufId;
			setupSeen_q <= 1'b1;
		end
		else if (wr && paddr == `QSD_OFF_STAT)
			setupSeen_q <= 1'b0;
	end

	assign link.cmdTag      = cmd_q[`QSD_CMD_TAG_HI:`QSD_CMD_TAG_LO];
	assign link.cmdCount    = cmd_q[15:0];
	assign link.cmdFeatures = feat_q;
	assign link.cmdLba      = {lbaHi_q, lbaLo_q};
	assign link.cmdAux      = aux_q;
	assign link.cmdValid    = cmdValid_q;
	assign link.qwData      = {qwHi_q, qwLo_q};
	assign link.qwValid     = qwValid_q;
	assign link.qwLast      = qwLast_q;
	assign prdata           = prdata_q;
	assign pready           = pready_q;
	assign pslverr          = pslverr_q;
endmodule

// >>> dv/qsd_link_monitor.sv
// Checker of the link between the host end and the device end.
// Assumes the bench ends each barrier no sooner than four cycles on.
`timescale 1ns/1ps
`include "qsd_cfg.svh"
module qsd_link_monitor
(
	input wire logic                 sys_clk,
	input wire logic                 rst_b,
	input wire logic                 cmdValid,
	input wire logic                 cmdReady,
	input wire qsd_pkg::qsd_tag_type cmdTag,
	input wire logic [15:0]          cmdCount,
	input wire logic [31:0]          cmdAux,
	input wire logic                 qwValid,
	input wire logic                 qwReady,
	input wire logic                 dmaSetup,
	input wire qsd_pkg::qsd_tag_type dmaBufId
);
	function automatic logic [31:0] rsvdMask(input logic [4:0] s);
		case (s)
			5'h01: return `QSD_RSVD_EVICT;
			5'h02: return `QSD_RSVD_LOG;
			5'h03: return `QSD_RSVD_ZONED;
			default: return `QSD_RSVD_RANGE;
		endcase
	endfunction

	default clocking mcb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	logic       take;
	logic       good;
	logic [4:0] sub;
	assign take = cmdValid && cmdReady;
	assign sub = cmdCount[12:8];
	assign good = sub < 5'h05 && (cmdAux & rsvdMask(sub)) == 32'h0;

	a_bufid_is_tag: assert property (
		take && good && sub != 5'h03 |=> dmaSetup && dmaBufId == $past(cmdTag))
		else $error("buffer id differs from command tag");
	a_setup_has_cause: assert property (
		dmaSetup |-> $past(take) && $past(good) && $past(sub) != 5'h03)
		else $error("buffer select without a valid command");
	a_zoned_no_setup: assert property (
		take && sub == 5'h03 |=> !dmaSetup)
		else $error("buffer select after a non-data command");
	a_rsvd_no_setup: assert property (
		take && !good |=> !dmaSetup)
		else $error("buffer select after an invalid command");
	a_log_barrier: assert property (
		take && good && sub == 5'h02 |=> !cmdReady [*3])
		else $error("command taken past a sequential one");
	a_zoned_barrier: assert property (
		take && good && sub == 5'h03 |=> !cmdReady [*3])
		else $error("command taken past an ordered one");
	a_plain_ready_back: assert property (
		take && good && sub != 5'h02 && sub != 5'h03 |-> ##2 cmdReady)
		else $error("ready withheld after an unordered command");
	a_setup_one_pulse: assert property (
		dmaSetup |=> !dmaSetup)
		else $error("buffer select longer than one cycle");
	a_data_no_stall: assert property (
		qwValid |-> qwReady)
		else $error("range entry stalled");
endmodule

// >>> dv/tb.sv
// Bench joining host and device ends; drives APB and checks the decodes.
// Assumes one 50 MHz clock and reset held low for 16 cycles.
`timescale 1ns/1ps
`include "qsd_cfg.svh"
module tb;
	typedef struct {
		logic [4:0]  tag;
		logic [15:0] cnt;
		logic [15:0] ft;
		logic [47:0] lba;
		logic [31:0] aux;
	} qsd_cmd_type;

	logic                 sys_clk = 1'b0;
	logic                 rst_b = 1'b0;
	logic                 psel = 1'b0;
	logic                 penable = 1'b0;
	logic                 pwrite = 1'b0;
	logic                 cmdDone = 1'b0;
	logic [11:0]          paddr = 12'h000;
	logic [31:0]          pwdata = 32'h0;
	logic [31:0]          prdata, rd, p;
	logic                 pready, pslverr, er, decValid, decInvalid;
	logic                 decSequential, decOrdered, decDiscard;
	logic                 rngValid, rngListEnd, bad, ok;
	qsd_pkg::qsd_tag_type decTag;
	logic [4:0]           decSubcode, s, ds;
	logic [15:0]          decCount, decFeatures, rngLength;
	logic [47:0]          decAddress, rngStart;
	logic [7:0]           decFunction;
	logic [5:0]           rngIndex;
	logic [69:0]          r;
	logic [69:0]          rq[$];
	qsd_cmd_type          c, dc;
	qsd_cmd_type          cq[$];
	int                   n_fail = 0, n_tests = 0, nDec = 0, nEnd = 0, n, i;

	qsd_link_if lnk ();
	qsd_host_end qsd_host_end_i (.sys_clk, .rst_b, .link(lnk), .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	qsd_device_end qsd_device_end_i (.sys_clk, .rst_b, .link(lnk), .cmdDone,
		.decValid, .decTag, .decSubcode, .decInvalid, .decSequential,
		.decOrdered, .decCount, .decAddress, .decFeatures, .decDiscard,
		.decFunction, .rngValid, .rngIndex, .rngLength, .rngStart,
		.rngListEnd);
	qsd_link_monitor qsd_link_monitor_i (.sys_clk, .rst_b,
		.cmdValid(lnk.cmdValid), .cmdReady(lnk.cmdReady),
		.cmdTag(lnk.cmdTag), .cmdCount(lnk.cmdCount), .cmdAux(lnk.cmdAux),
		.qwValid(lnk.qwValid), .qwReady(lnk.qwReady),
		.dmaSetup(lnk.dmaSetup), .dmaBufId(lnk.dmaBufId));

	always #10 sys_clk = ~sys_clk;

	function automatic logic [31:0] rsvd(input logic [4:0] v);
		case (v)
			5'h01: return `QSD_RSVD_EVICT;
			5'h02: return `QSD_RSVD_LOG;
			5'h03: return `QSD_RSVD_ZONED;
			default: return `QSD_RSVD_RANGE;
		endcase
	endfunction

	function void chk(input string w, input logic [63:0] e,
		input logic [63:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", w, e, g);
		end
	endfunction

	task complete_run;
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Request held until pready is seen at an edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Field writes are dropped while anything is pending
	task waitIdle;
		do
			apb(1'b0, `QSD_OFF_CTRL, 32'h0);
		while (rd[1:0] !== 2'b00);
	endtask

	task finishCmd;
		@(posedge sys_clk);
		cmdDone <= 1'b1;
		@(posedge sys_clk);
		cmdDone <= 1'b0;
	endtask

	task settle;
		waitIdle;
		repeat (4) @(posedge sys_clk);
		finishCmd;
	endtask

	task issue(input qsd_cmd_type x);
		cq.push_back(x);
		apb(1'b1, `QSD_OFF_CMD, {11'h0, x.tag, x.cnt});
		apb(1'b1, `QSD_OFF_FEAT, {16'h0, x.ft});
		apb(1'b1, `QSD_OFF_LBALO, x.lba[31:0]);
		apb(1'b1, `QSD_OFF_LBAHI, {16'h0, x.lba[47:32]});
		apb(1'b1, `QSD_OFF_AUX, x.aux);
		apb(1'b1, `QSD_OFF_CTRL, 32'h1);
	endtask

	// Starts rise with the index, so the host order stays sorted
	task sendList(input int nq, input int z);
		logic [63:0] q;
		for (int j = 0; j < nq; j++)
		begin
			q = {(j == z) ? 16'h0000 : 16'($urandom_range(65535, 1)),
				8'h00, 20'(j), 20'($urandom)};
			if (j < z)
				rq.push_back({6'(j), q});
			apb(1'b1, `QSD_OFF_QWLO, q[31:0]);
			apb(1'b1, `QSD_OFF_QWHI, q[63:32]);
			apb(1'b1, `QSD_OFF_CTRL, {28'h0, 2'b10, j == nq - 1, 1'b0});
			waitIdle;
		end
	endtask

	always @(posedge sys_clk)
	begin
		if (decValid === 1'b1)
		begin
			nDec++;
			dc = cq.pop_front();
			ds = dc.cnt[12:8];
			bad = ds >= 5'h05 || (dc.aux & rsvd(ds)) != 32'h0;
			chk("decTag", dc.tag, decTag);
			chk("decSubcode", ds, decSubcode);
			chk("decInvalid", bad, decInvalid);
			if (!bad)
				chk("decSequential", ds == 5'h02, decSequential);
			if (!bad)
				chk("decOrdered", ds == 5'h03, decOrdered);
			chk("decCount", dc.ft, decCount);
			chk("decAddress", dc.lba, decAddress);
			chk("decFeatures", dc.aux[15:0], decFeatures);
			chk("decDiscard", dc.aux[0], decDiscard);
			chk("decFunction", dc.aux[15:8], decFunction);
		end
		if (rngValid === 1'b1)
		begin
			r = rq.pop_front();
			chk("rngIndex", r[69:64], rngIndex);
			chk("rngLength", r[63:48], rngLength);
			chk("rngStart", r[47:0], rngStart);
		end
		if (rngListEnd === 1'b1)
			nEnd++;
	end

	initial
	begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		complete_run;
	end

	initial
	begin
		void'($urandom(32'h78b80ac5));
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		apb(1'b0, 12'h040, 32'h0);
		chk("pslverr", 1'b1, er);
		// Every code, reserved ones included; stray aux bits only on evict, zoned and reserved codes
		for (i = 0; i < 36; i++)
		begin
			c.tag = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
			s = (i % 6 == 5) ? 5'($urandom_range(31, 5)) : 5'(i % 6);
			c.cnt = {3'h0, s, 8'($urandom)};
			c.ft = 16'($urandom);
			c.lba = {16'($urandom), 32'($urandom)};
			c.aux = $urandom & ~((i % 4 == 3) ? 32'h0 : rsvd(s));
			p = $urandom;
			apb(1'b1, 12'(`QSD_OFF_PTR + 4 * c.tag), p);
			issue(c);
			settle;
			ok = s < 5'h05 && s != 5'h03
				&& (c.aux & rsvd(s)) == 32'h0;
			apb(1'b0, `QSD_OFF_STAT, 32'h0);
			chk("setupSeen", ok, rd[5]);
			if (ok)
			begin
				chk("lastBufId", c.tag, rd[4:0]);
				apb(1'b0, `QSD_OFF_BASE, 32'h0);
				chk("activeBase", p, rd);
			end
			// Any status write clears the seen flag for the next command
			apb(1'b1, `QSD_OFF_STAT, 32'h0);
		end
		// Barrier codes hold a follow-up command back
		for (i = 2; i < 4; i++)
		begin
			c.cnt = {3'h0, 5'(i), 8'h01};
			c.aux = 32'h0;
			issue(c);
			repeat (8) @(posedge sys_clk);
			n = nDec;
			c.cnt = 16'h0001;
			issue(c);
			repeat (10) @(posedge sys_clk);
			chk("heldBack", n, nDec);
			finishCmd;
			settle;
		end
		sendList(66, 99);
		sendList(5, 2);
		sendList(3, 0);
		repeat (4) @(posedge sys_clk);
		chk("listEnds", 3, nEnd);
		chk("rangesLeft", 0, rq.size());
		chk("cmdsLeft", 0, cq.size());
		complete_run;
	end
endmodule
